// file: inc/viu_pkg.sv
package viu_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] VIU_ADDR_MASK = 8'hDD;
  localparam logic [7:0] VIU_ADDR_MODE = 8'hDE;
  localparam logic [7:0] VIU_ADDR_PRIO = 8'hFF;
  localparam logic [7:0] VIU_ADDR_SRCEN = 8'hC0;
  localparam logic [7:0] VIU_ADDR_PEND = 8'hC4;
  localparam logic [7:0] VIU_ADDR_IRQST = 8'hC8;
  localparam logic [7:0] VIU_ADDR_IRQMSK = 8'hCC;
  localparam logic [7:0] VIU_ADDR_IPTR = 8'hD0;
  localparam logic [7:0] VIU_ADDR_PC = 8'hD4;
  localparam logic [7:0] VIU_ADDR_FLAGS = 8'hD8;
  localparam logic [7:0] VIU_ADDR_STATE = 8'hE0;
  // Mode register fields and the fast bit of the flags
  localparam int VIU_MODE_GIE = 0;
  localparam int VIU_MODE_FEN = 1;
  localparam int VIU_MODE_FSEL_LSB = 2;
  localparam int VIU_FAST_FLAG = 1;
  // Reset values and vector base
  localparam logic [7:0] VIU_RST_BYTE = 8'h00;
  localparam logic [15:0] VIU_RST_WORD = 16'h0000;
  localparam logic [15:0] VIU_VEC_BASE = 16'h0000;
  // Entry timing in clock periods, AXI responses and sequencer states
  localparam int VIU_FAST_CYC = 6;
  localparam int VIU_NORM_CYC = 22;
  localparam logic [1:0] VIU_RESP_OK = 2'h0;
  localparam logic [1:0] VIU_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {VIU_IDLE, VIU_NORM, VIU_FAST} viu_seq_t;
endpackage

// file: rtl/viu_top.sv
`timescale 1ns/1ps
module viu_top
  import viu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Requests: internal levels, external edges (pins)
  input wire logic [7:0] int_req,
  input wire logic [7:0] ext_req_pin,
  // Core sequencer
  input wire logic [15:0] core_pc,
  input wire logic [7:0] core_flags,
  input wire logic core_return_from_interrupt,
  output logic push_valid,
  output logic [15:0] push_pc,
  output logic [7:0] push_flags,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic flags_load,
  output logic [7:0] flags_value,
  output logic entry_busy,
  output logic [2:0] grant_level,
  output logic [2:0] grant_source,
  output logic irq
);
  import viu_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] mode;
    logic [7:0] prio;
    logic [7:0] srcen;
    logic [7:0] ext_cap;
    logic [7:0] ext_s1;
    logic [7:0] ext_s2;
    logic [7:0] ext_old;
    logic [1:0] ist;
    logic [1:0] imsk;
    logic [15:0] iptr;
    logic [7:0] shadow;
    logic fast_act;
    viu_seq_t seq;
    logic [4:0] cnt;
    logic [15:0] pc_save;
    logic [7:0] fl_save;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic push_valid;
    logic pc_load;
    logic [15:0] pc_value;
    logic flags_load;
    logic [7:0] flags_value;
    logic [2:0] glev;
    logic [2:0] gsrc;
    logic irq;
    logic busy;
  } viu_state_t;

  viu_state_t s_q;
  viu_state_t s_d;

  // Level priority from the priority register: only prio[2:0] is used,
  // a 3-bit ring offset over levels 0..7 that wrap around;
  // the level at offset prio[2:0] wins first, then upward.
  function automatic logic [2:0] viu_rot(input logic [2:0] base,
                                         input logic [2:0] i);
    viu_rot = 3'(base + i);
  endfunction

  // Vectors are two bytes apart, one per level
  function automatic logic [15:0] viu_vector(input logic [2:0] lev);
    viu_vector = VIU_VEC_BASE + {12'h000, lev, 1'b0};
  endfunction

  logic [7:0] req_lvl;
  logic [7:0] ext_edge;
  logic win;
  logic [2:0] wlev;
  logic is_fast;
  logic [7:0] wb;
  logic [7:0] mode_w;
  logic grant_now;
  logic entry_done;

  always_comb
  begin
    s_d = s_q;
    // Two-flop synchroniser, then edge detect on the second flop
    s_d.ext_s1 = ext_req_pin;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_old = s_q.ext_s2;
    ext_edge = s_q.ext_s2 & ~s_q.ext_old;
    // One request per level: source i feeds level i
    req_lvl = (int_req | s_q.ext_cap) & s_q.srcen;
    req_lvl = req_lvl & s_q.mask;
    win = 1'b0;
    wlev = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (req_lvl[viu_rot(s_q.prio[2:0], 3'(i))])
      begin
        win = 1'b1;
        wlev = viu_rot(s_q.prio[2:0], 3'(i));
      end
    end
    // Only the selected level may take the swap path
    is_fast = s_q.mode[VIU_MODE_FEN] &&
              (s_q.mode[VIU_MODE_FSEL_LSB +: 3] == wlev);

    s_d.push_valid = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.flags_load = 1'b0;
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    s_d.arready = 1'b0;

    unique case (s_q.seq)
      VIU_IDLE:
      begin
        if (win && s_q.mode[VIU_MODE_GIE] && !core_return_from_interrupt)
        begin
          s_d.mode[VIU_MODE_GIE] = 1'b0;
          s_d.glev = wlev;
          s_d.gsrc = wlev;
          // Saved PC feeds both the stack push and the pointer swap
          s_d.pc_save = core_pc;
          s_d.fl_save = core_flags;
          s_d.ist[0] = 1'b1;
          if (is_fast)
          begin
            s_d.seq = VIU_FAST;
            s_d.cnt = 5'(VIU_FAST_CYC - 1);
          end
          else
          begin
            s_d.seq = VIU_NORM;
            s_d.cnt = 5'(VIU_NORM_CYC - 1);
          end
        end
        else if (core_return_from_interrupt)
        begin
          // Normal return: the core pops its own PC and flags
          s_d.mode[VIU_MODE_GIE] = 1'b1;
          if (s_q.fast_act)
          begin
            s_d.pc_load = 1'b1;
            s_d.pc_value = s_q.iptr;
            s_d.iptr = core_pc;
            s_d.flags_load = 1'b1;
            s_d.flags_value = s_q.shadow & ~8'(1 << VIU_FAST_FLAG);
            s_d.fast_act = 1'b0;
          end
        end
      end
      VIU_NORM:
      begin
        s_d.cnt = s_q.cnt - 5'h01;
        if (s_q.cnt == 5'h01)
        begin
          // Push and vector load leave together, one cycle before the end
          s_d.push_valid = 1'b1;
          s_d.pc_load = 1'b1;
          s_d.pc_value = viu_vector(s_q.glev);
        end
        if (s_q.cnt == 5'h00)
          s_d.seq = VIU_IDLE;
      end
      VIU_FAST:
      begin
        s_d.cnt = s_q.cnt - 5'h01;
        if (s_q.cnt == 5'h01)
        begin
          // Swap, shadow copy and fast bit all land on one edge
          s_d.pc_load = 1'b1;
          s_d.pc_value = s_q.iptr;
          s_d.iptr = s_q.pc_save;
          s_d.shadow = s_q.fl_save;
          s_d.flags_load = 1'b1;
          s_d.flags_value = s_q.fl_save | 8'(1 << VIU_FAST_FLAG);
          s_d.fast_act = 1'b1;
        end
        if (s_q.cnt == 5'h00)
          s_d.seq = VIU_IDLE;
      end
    endcase

    // Events shared by the status bits and the enable-clear race
    grant_now = (s_q.seq == VIU_IDLE) && (s_d.seq != VIU_IDLE);
    entry_done = (s_q.cnt == 5'h00) && (s_q.seq != VIU_IDLE);
    s_d.busy = (s_d.seq != VIU_IDLE);

    // AXI write: take address and data in either order
    // Ready pulses a cycle after valid; the payload is latched at once
    if (s_axi_awvalid && !s_q.aw_got && !s_q.awready)
    begin
      s_d.awready = 1'b1;
      s_d.aw_got = 1'b1;
      // Word-spaced registers: low address bits are not decoded
      s_d.aw_addr = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !s_q.w_got && !s_q.wready)
    begin
      s_d.wready = 1'b1;
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    wb = s_q.w_data[7:0];
    mode_w = s_d.mode;
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = VIU_RESP_OK;
      if (s_q.w_strb[0])
      begin
        unique case (s_q.aw_addr)
          VIU_ADDR_MASK: s_d.mask = wb;
          VIU_ADDR_MODE:
          begin
            // Hardware clearing of the enable on grant wins
            mode_w = wb;
            if (grant_now)
              mode_w[VIU_MODE_GIE] = 1'b0;
            s_d.mode = mode_w;
          end
          VIU_ADDR_PRIO: s_d.prio = wb;
          VIU_ADDR_SRCEN: s_d.srcen = wb;
          VIU_ADDR_PEND: s_d.ext_cap = s_q.ext_cap & ~wb;
          VIU_ADDR_IRQMSK: s_d.imsk = wb[1:0];
          VIU_ADDR_IPTR: s_d.iptr[7:0] = wb;
          VIU_ADDR_PC, VIU_ADDR_FLAGS, VIU_ADDR_IRQST, VIU_ADDR_STATE: ;
          default: s_d.bresp = VIU_RESP_SLVERR;
        endcase
      end
      // Pointer is the only writable register wider than a byte
      if (s_q.w_strb[1] && s_q.aw_addr == VIU_ADDR_IPTR)
        s_d.iptr[15:8] = s_q.w_data[15:8];
    end

    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Edge capture; a new edge wins over a clear
    s_d.ext_cap = s_d.ext_cap | ext_edge;
    if (entry_done)
      s_d.ist[1] = 1'b1;

    // AXI read
    // Read answer is registered; rvalid holds until rready
    if (s_axi_arvalid && !s_q.rvalid && !s_q.arready)
    begin
      s_d.arready = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp = VIU_RESP_OK;
      s_d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr[9:2])
        VIU_ADDR_MASK: s_d.rdata[7:0] = s_q.mask;
        VIU_ADDR_MODE: s_d.rdata[7:0] = s_q.mode;
        VIU_ADDR_PRIO: s_d.rdata[7:0] = s_q.prio;
        VIU_ADDR_SRCEN: s_d.rdata[7:0] = s_q.srcen;
        VIU_ADDR_PEND: s_d.rdata[7:0] = s_q.ext_cap;
        VIU_ADDR_IRQMSK: s_d.rdata[1:0] = s_q.imsk;
        VIU_ADDR_IPTR: s_d.rdata[15:0] = s_q.iptr;
        VIU_ADDR_PC: s_d.rdata[15:0] = s_q.pc_save;
        VIU_ADDR_FLAGS: s_d.rdata[7:0] = s_q.shadow;
        VIU_ADDR_STATE:
          s_d.rdata[7:0] = {s_q.fast_act, 1'b0, s_q.seq, s_q.glev, win};
        VIU_ADDR_IRQST:
        begin
          s_d.rdata[1:0] = s_q.ist;
          // Read clears, but an event this cycle survives
          s_d.ist = s_d.ist & ~s_q.ist;
          if (grant_now)
            s_d.ist[0] = 1'b1;
          if (entry_done)
            s_d.ist[1] = 1'b1;
        end
        default: s_d.rresp = VIU_RESP_SLVERR;
      endcase
    end

    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    // Irq follows the next state, so it rises with its status bit
    s_d.irq = |(s_d.ist & s_d.imsk);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Clearing the whole state leaves the global enable off
      s_q <= '0;
      s_q.seq <= VIU_IDLE;
      s_q.iptr <= VIU_RST_WORD;
      s_q.mask <= VIU_RST_BYTE;
    end
    else
      s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign push_valid = s_q.push_valid;
  assign push_pc = s_q.pc_save;
  assign push_flags = s_q.fl_save;
  assign pc_load = s_q.pc_load;
  assign pc_value = s_q.pc_value;
  assign flags_load = s_q.flags_load;
  assign flags_value = s_q.flags_value;
  assign entry_busy = s_q.busy;
  assign grant_level = s_q.glev;
  assign grant_source = s_q.gsrc;
  assign irq = s_q.irq;
endmodule

// file: tb/viu_sva.sv
`timescale 1ns/1ps
module viu_sva
  import viu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  input wire logic core_return_from_interrupt,
  input wire logic push_valid,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic flags_load,
  input wire logic [7:0] flags_value,
  input wire logic entry_busy,
  input wire logic [2:0] grant_level,
  input wire logic [2:0] grant_source,
  input wire logic irq,
  // Stack push against the state seen at grant
  input wire logic [15:0] core_pc,
  input wire logic [7:0] core_flags,
  input wire logic [15:0] push_pc,
  input wire logic [7:0] push_flags
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [4:0] busy_cnt_q;
  always_ff @(posedge aclk)
    busy_cnt_q <= (!aresetn || !entry_busy) ? 5'h00 : busy_cnt_q + 5'h01;
  a_push_loads: assert property (push_valid |-> pc_load && !flags_load)
    else $error("push without vector load");
  a_vector_addr: assert property (push_valid |->
    pc_value == VIU_VEC_BASE + {12'h000, grant_level, 1'b0})
    else $error("vector address wrong");
  a_entry_span: assert property (busy_cnt_q < 5'h17)
    else $error("entry longer than normal span");
  a_push_late: assert property (push_valid |-> $past(entry_busy, 15))
    else $error("normal entry too short");
  a_fast_early: assert property (flags_load && !$past(core_return_from_interrupt)
    |-> $past(entry_busy, 3)) else $error("fast entry timing wrong");
  a_fast_set: assert property (flags_load && !$past(core_return_from_interrupt)
    |-> flags_value[VIU_FAST_FLAG]) else $error("fast bit not set");
  a_ret_clear: assert property ($past(core_return_from_interrupt) && flags_load
    |-> !flags_value[VIU_FAST_FLAG]) else $error("fast bit not cleared");
  a_load_pulse: assert property (pc_load |=> !pc_load)
    else $error("pc load not a pulse");
  a_push_pc: assert property (push_valid |->
    push_pc == $past(core_pc, VIU_NORM_CYC)) else $error("pushed pc wrong");
  a_push_flags: assert property (push_valid |->
    push_flags == $past(core_flags, VIU_NORM_CYC))
    else $error("pushed flags wrong");
  a_source_level: assert property (grant_source == grant_level)
    else $error("source and level differ");
  c_normal: cover property (push_valid);
  c_fast: cover property (flags_load && flags_value[VIU_FAST_FLAG]);
  c_irq: cover property (irq && entry_busy);
endmodule
bind viu_top viu_sva u_sva (.aclk, .aresetn, .core_return_from_interrupt, .push_valid,
  .pc_load, .pc_value, .flags_load, .flags_value, .entry_busy,
  .grant_level, .grant_source, .irq, .core_pc, .core_flags, .push_pc,
  .push_flags);

// file: tb/viu_core_model.sv
`timescale 1ns/1ps
module viu_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // From the unit
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic flags_load,
  input wire logic [7:0] flags_value,
  // From the bench
  input wire logic ret_req,
  // To the unit
  output logic [15:0] core_pc,
  output logic [7:0] core_flags,
  output logic core_return_from_interrupt
);
  // Stalled core: pc only moves on loads, so swaps are predictable
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      core_pc <= 16'h0100;
      core_flags <= 8'h5C;
      core_return_from_interrupt <= 1'b0;
    end
    else
    begin
      core_pc <= pc_load ? pc_value : core_pc;
      core_flags <= flags_load ? flags_value : core_flags;
      core_return_from_interrupt <= ret_req;
    end
endmodule

// file: tb/viu_top_tb.sv
`timescale 1ns/1ps
module viu_top_tb;
  import viu_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, ret_req;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0] int_req, ext_req_pin;
  logic [31:0] s_axi_wdata, rdata_v;
  logic [1:0] rresp_v;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, core_return_from_interrupt, pc_load, flags_load, entry_busy, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] core_pc, pc_value;
  wire logic [7:0] core_flags, flags_value;
  wire logic [2:0] grant_level;
  integer error_cnt = 0, checks_done = 0, seed = 32'hE271, i, n;
  logic [15:0] exp_q[$], cur_pc, saved, p;
  logic [7:0] ra [3] = '{VIU_ADDR_MASK, VIU_ADDR_MODE, VIU_ADDR_PRIO};
  viu_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_req, .ext_req_pin,
    .core_pc, .core_flags, .core_return_from_interrupt, .push_valid(), .push_pc(),
    .push_flags(), .pc_load, .pc_value, .flags_load, .flags_value,
    .entry_busy, .grant_level, .grant_source(), .irq);
  viu_core_model u_core (.aclk, .aresetn, .pc_load, .pc_value, .flags_load,
    .flags_value, .ret_req, .core_pc, .core_flags, .core_return_from_interrupt);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    // Register index times four gives the byte address
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (s_axi_rvalid !== 1'b1);
    rdata_v = s_axi_rdata;
    rresp_v = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task req(input logic [7:0] v);
    @(posedge aclk);
    int_req <= v;
  endtask
  task ret;
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask
  task want_pc(input logic [15:0] v);
    exp_q.push_back(v);
    cur_pc = v;
  endtask
  task settle;
    for (i = 0; i < 60 && exp_q.size() > 0; i++) @(posedge aclk);
    check(32'(exp_q.size()), 32'h0);
  endtask
  task idle_chk;
    repeat (30) @(posedge aclk);
    check(32'(entry_busy), 32'h0);
  endtask
  // Loads are pulses, so sample them away from the launching edge
  always @(negedge aclk)
    if (pc_load === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(32'(pc_value), 32'(exp_q.pop_front()));
    end
  initial
  begin
    repeat (8000) @(posedge aclk);
    error_cnt++;
    complete_run;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ret_req, int_req, ext_req_pin} = 19'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    cur_pc = 16'h0100;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[k])
    begin
      rd(ra[k]);
      check(rdata_v, 32'h0);
    end
    rd(8'h10);
    check(32'(rresp_v), 32'(VIU_RESP_SLVERR));
    wr(VIU_ADDR_SRCEN, 32'hFF);
    wr(VIU_ADDR_MASK, 32'hFF);
    wr(VIU_ADDR_IRQMSK, 32'h1);
    req(8'h08);
    idle_chk();
    wr(VIU_ADDR_MASK, 32'hF7);
    wr(VIU_ADDR_MODE, 32'h1);
    idle_chk();
    wr(VIU_ADDR_SRCEN, 32'hF7);
    wr(VIU_ADDR_MASK, 32'hFF);
    idle_chk();
    want_pc(16'h0006);
    wr(VIU_ADDR_SRCEN, 32'hFF);
    settle();
    check(32'(irq), 32'h1);
    rd(VIU_ADDR_MODE);
    check(rdata_v, 32'h0);
    rd(VIU_ADDR_IRQST);
    check(rdata_v & 32'h1, 32'h1);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    req(8'h00);
    ret();
    rd(VIU_ADDR_MODE);
    check(rdata_v, 32'h1);
    for (n = 0; n < 3; n++)
    begin
      p = 16'($random(seed)) & 16'h0007;
      wr(VIU_ADDR_PRIO, 32'(p));
      want_pc(p << 1);
      req(8'($random(seed)) | (8'h01 << p[2:0]));
      settle();
      check(32'(grant_level), 32'(p));
      req(8'h00);
      ret();
    end
    wr(VIU_ADDR_IPTR, 32'h1234);
    wr(VIU_ADDR_MODE, 32'h16);
    saved = cur_pc;
    want_pc(16'h1234);
    req(8'h20);
    wr(VIU_ADDR_MODE, 32'h17);
    settle();
    for (n = 0; n < 2; n++)
    begin
      req(8'h00);
      want_pc(saved);
      ret();
      settle();
      want_pc(16'h1234);
      req(8'h20);
      settle();
    end
    req(8'h00);
    want_pc(saved);
    ret();
    settle();
    want_pc(16'h0002);
    req(8'h02);
    settle();
    req(8'h00);
    ret();
    wr(VIU_ADDR_MODE, 32'h0);
    ext_req_pin <= 8'h10;
    repeat (4) @(posedge aclk);
    ext_req_pin <= 8'h00;
    wr(VIU_ADDR_PEND, 32'h10);
    wr(VIU_ADDR_MODE, 32'h1);
    idle_chk();
    want_pc(16'h0008);
    ext_req_pin <= 8'h10;
    settle();
    wr(VIU_ADDR_PEND, 32'h10);
    ret();
    idle_chk();
    complete_run();
  end
endmodule
